// File: rtl/bsc_top.sv
/*
 * Bin sorting comparator: APB register file, limit tables, sequential
 * list loader, bin counters and the classification stage.
 * Assumes a same-clock measurement engine and an APB master on clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bsc_top
  import bsc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire bsc_apb_req_t apb,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire bsc_meas_t    meas,
  output bsc_result_t       result
);

  logic                   comp_en_r;
  logic                   aux_en_r;
  logic                   swap_r;
  logic                   cnt_en_r;
  bsc_mode_t              mode_r;
  bsc_val_t               nom_r;
  bsc_val_t               stage_r;
  bsc_val_t               sec_lo_r;
  bsc_val_t               sec_hi_r;
  logic                   sec_valid_r;
  bsc_val_t [BSC_NBINS-1:0] lo_r;
  bsc_val_t [BSC_NBINS-1:0] hi_r;
  logic [BSC_NBINS-1:0]   valid_r;
  bsc_val_t               seq_first_r;
  logic [3:0]             seq_wr_r;
  logic [3:0]             seq_rd_r;
  logic [31:0]            cnt_r [BSC_NCNT];
  logic                   err_r;
  logic [3:0]             last_code_r;
  logic                   pready_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;

  logic                   access;
  logic                   wr_go;
  logic                   rd_go;
  logic [7:0]             addr;
  logic [31:0]            wdata;
  bsc_val_t               wval;
  logic                   mapped;
  logic [31:0]            rd_mux;
  logic                   err_set;
  logic                   bin_wr;
  logic [3:0]             bin_idx;
  logic                   bin_hi_sel;
  logic                   cnt_sel;
  logic [3:0]             cnt_idx;
  logic                   seq_ok;
  bsc_val_t               seq_prev;

  assign addr   = apb.paddr;
  assign wdata  = apb.pwdata;
  assign wval   = bsc_val_t'(apb.pwdata);
  assign access = apb.psel && apb.penable;
  assign wr_go  = access && pready_r && apb.pwrite;
  assign rd_go  = access && pready_r && !apb.pwrite;

  // Bin limit window 0x40..0x87, counters 0x90..0xbb
  function automatic logic in_win(input logic [7:0] a,
                                  input logic [7:0] base,
                                  input logic [7:0] words);
    return (a >= base) && (a < 8'(base + (words << 2))) && (a[1:0] == 2'b00);
  endfunction

  always_comb begin
    bin_wr     = in_win(addr, BSC_OFS_BIN, 8'(2 * BSC_NBINS));
    bin_idx    = 4'(8'(addr - BSC_OFS_BIN) >> 3);
    bin_hi_sel = addr[2];
    cnt_sel    = in_win(addr, BSC_OFS_CNT, 8'(BSC_NCNT));
    cnt_idx    = 4'(8'(addr - BSC_OFS_CNT) >> 2);
  end

  // Entries rise strictly; ten at most, the last high is bin nine
  always_comb begin
    seq_prev = (seq_wr_r == 4'h1) ? seq_first_r :
               hi_r[(seq_wr_r >= 4'h2) ? 4'(seq_wr_r - 4'h2) : 4'h0];
    seq_ok   = (seq_wr_r == 4'h0) ||
               ((seq_wr_r < BSC_SEQ_LAST) && (wval > seq_prev));
  end

  always_comb begin
    mapped = bin_wr || cnt_sel;
    case (addr)
      BSC_OFS_STATE, BSC_OFS_MODE, BSC_OFS_MNAME, BSC_OFS_NOM,
      BSC_OFS_STAGE, BSC_OFS_SEC_HI, BSC_OFS_SEC_LO, BSC_OFS_AUX,
      BSC_OFS_SWAP, BSC_OFS_CNTEN, BSC_OFS_SEQPTR, BSC_OFS_SEQ,
      BSC_OFS_BCLR, BSC_OFS_CCLR, BSC_OFS_STAT: mapped = 1'b1;
      default: ;
    endcase
  end

  // Refused writes: bad on/off code, bad mode, pair not rising, list entry not rising or past ten
  always_comb begin
    err_set = 1'b0;
    if (wr_go) begin
      case (addr)
        BSC_OFS_STATE, BSC_OFS_AUX, BSC_OFS_SWAP, BSC_OFS_CNTEN:
          err_set = !bsc_onoff_ok(wdata);
        BSC_OFS_MODE:
          err_set = wdata > 32'(BSC_MODE_SEQ);
        BSC_OFS_SEC_HI:
          err_set = stage_r >= wval;
        BSC_OFS_SEQ:
          err_set = !seq_ok;
        default:
          err_set = bin_wr && bin_hi_sel && (stage_r >= wval);
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      comp_en_r <= 1'b0;
      aux_en_r  <= 1'b0;
      swap_r    <= 1'b0;
      cnt_en_r  <= 1'b0;
    end else if (wr_go && bsc_onoff_ok(wdata)) begin
      case (addr)
        BSC_OFS_STATE: comp_en_r <= bsc_onoff_val(wdata);
        BSC_OFS_AUX:   aux_en_r  <= bsc_onoff_val(wdata);
        BSC_OFS_SWAP:  swap_r    <= bsc_onoff_val(wdata);
        BSC_OFS_CNTEN: cnt_en_r  <= bsc_onoff_val(wdata);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_r <= BSC_MODE_ABS;
      nom_r  <= BSC_VAL_RST;
    end else if (wr_go) begin
      if (addr == BSC_OFS_MODE && !err_set) begin
        mode_r <= bsc_mode_t'(wdata[1:0]);
      end
      if (addr == BSC_OFS_NOM) begin
        nom_r <= wval;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage_r     <= BSC_VAL_RST;
      sec_lo_r    <= BSC_VAL_RST;
      sec_hi_r    <= BSC_VAL_RST;
      sec_valid_r <= 1'b0;
    end else if (wr_go) begin
      if (addr == BSC_OFS_STAGE) begin
        stage_r <= wval;
      end
      if (addr == BSC_OFS_SEC_HI && !err_set) begin
        sec_lo_r    <= stage_r;
        sec_hi_r    <= wval;
        sec_valid_r <= 1'b1;
      end
    end
  end

  // Limit table: per-bin pairs, sequential list and clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lo_r        <= '0;
      hi_r        <= '0;
      valid_r     <= '0;
      seq_first_r <= BSC_VAL_RST;
      seq_wr_r    <= 4'h0;
    end else if (wr_go) begin
      if (addr == BSC_OFS_BCLR) begin
        lo_r     <= '0;
        hi_r     <= '0;
        valid_r  <= '0;
        seq_wr_r <= 4'h0;
      end else if (addr == BSC_OFS_SEQPTR) begin
        seq_wr_r <= 4'h0;
      end else if (addr == BSC_OFS_SEQ && !err_set) begin
        seq_wr_r <= 4'(seq_wr_r + 4'h1);
        if (seq_wr_r == 4'h0) begin
          seq_first_r <= wval;
          valid_r     <= '0;
        end else begin
          lo_r[4'(seq_wr_r - 4'h1)]    <= seq_prev;
          hi_r[4'(seq_wr_r - 4'h1)]    <= wval;
          valid_r[4'(seq_wr_r - 4'h1)] <= 1'b1;
        end
      end else if (bin_wr && bin_hi_sel && !err_set) begin
        lo_r[bin_idx]    <= stage_r;
        hi_r[bin_idx]    <= wval;
        valid_r[bin_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      seq_rd_r <= 4'h0;
    end else if (wr_go && (addr == BSC_OFS_SEQPTR ||
                           addr == BSC_OFS_BCLR)) begin
      seq_rd_r <= 4'h0;
    end else if (rd_go && addr == BSC_OFS_SEQ && seq_rd_r < seq_wr_r) begin
      seq_rd_r <= 4'(seq_rd_r + 4'h1);
    end
  end

  // Error flag: a new error wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      err_r <= 1'b0;
    end else if (err_set) begin
      err_r <= 1'b1;
    end else if (wr_go && addr == BSC_OFS_STAT && wdata[BSC_STAT_ERR]) begin
      err_r <= 1'b0;
    end
  end

  bsc_classify u_classify (
    .clock     (clock),
    .rstn      (rstn),
    .meas      (meas),
    .enable    (comp_en_r),
    .aux_en    (aux_en_r),
    .swap      (swap_r),
    .mode      (mode_r),
    .nominal   (nom_r),
    .bin_lo    (lo_r),
    .bin_hi    (hi_r),
    .bin_valid (valid_r),
    .sec_lo    (sec_lo_r),
    .sec_hi    (sec_hi_r),
    .sec_valid (sec_valid_r),
    .result    (result)
  );

  // Counters; a clear drops a same-cycle count
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < BSC_NCNT; i++) begin
        cnt_r[i] <= 32'h00000000;
      end
    end else if (wr_go && addr == BSC_OFS_CCLR) begin
      for (int i = 0; i < BSC_NCNT; i++) begin
        cnt_r[i] <= 32'h00000000;
      end
    end else if (result.valid && cnt_en_r) begin
      cnt_r[4'(result.code - 4'h1)] <= 32'(cnt_r[4'(result.code - 4'h1)]
                                         + 32'h00000001);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      last_code_r <= 4'h0;
    end else if (result.valid) begin
      last_code_r <= result.code;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (addr)
      BSC_OFS_STATE:  rd_mux = {31'h0, comp_en_r};
      BSC_OFS_MODE:   rd_mux = {30'h0, mode_r};
      BSC_OFS_MNAME: begin
        case (mode_r)
          BSC_MODE_ABS: rd_mux = BSC_NAME_ABS;
          BSC_MODE_PCT: rd_mux = BSC_NAME_PCT;
          default:      rd_mux = BSC_NAME_SEQ;
        endcase
      end
      BSC_OFS_NOM:    rd_mux = nom_r;
      BSC_OFS_STAGE:  rd_mux = stage_r;
      BSC_OFS_SEC_HI: rd_mux = sec_hi_r;
      BSC_OFS_SEC_LO: rd_mux = sec_lo_r;
      BSC_OFS_AUX:    rd_mux = {31'h0, aux_en_r};
      BSC_OFS_SWAP:   rd_mux = {31'h0, swap_r};
      BSC_OFS_CNTEN:  rd_mux = {31'h0, cnt_en_r};
      BSC_OFS_SEQPTR: rd_mux = {28'h0, seq_wr_r};
      BSC_OFS_SEQ: begin
        if (seq_rd_r == 4'h0) begin
          rd_mux = seq_first_r;
        end else if (seq_rd_r < seq_wr_r) begin
          rd_mux = hi_r[4'(seq_rd_r - 4'h1)];
        end
      end
      BSC_OFS_STAT: begin
        rd_mux[BSC_STAT_ERR]            = err_r;
        rd_mux[BSC_STAT_CODE +: 4]      = last_code_r;
      end
      default: begin
        if (bin_wr) begin
          rd_mux = bin_hi_sel ? hi_r[bin_idx] : lo_r[bin_idx];
        end else if (cnt_sel) begin
          rd_mux = cnt_r[cnt_idx];
        end
      end
    endcase
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= access && !pready_r;
      pslverr_r <= access && !pready_r && !mapped;
      if (access && !pready_r && !apb.pwrite && mapped) begin
        prdata_r <= rd_mux;
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

endmodule // bsc_top

`default_nettype wire

// File: rtl/bsc_pkg.sv
/*
 * Package of the bin sorting comparator: register offsets, codes, reset
 * values, carrier structs and shared helper functions.
 * Assumes a 32-bit APB bus and signed integer measurement results.
 */
package bsc_pkg;

  typedef logic signed [31:0] bsc_val_t;

  typedef enum logic [1:0] {
    BSC_MODE_ABS,
    BSC_MODE_PCT,
    BSC_MODE_SEQ
  } bsc_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } bsc_apb_req_t;

  typedef struct packed {
    logic     valid;
    bsc_val_t primary;
    bsc_val_t secondary;
  } bsc_meas_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } bsc_result_t;

  localparam int         BSC_NBINS      = 9;
  localparam int         BSC_NCNT       = 11;
  localparam logic [3:0] BSC_SEQ_LAST   = 4'ha;

  // Register offsets
  localparam logic [7:0] BSC_OFS_STATE  = 8'h00;
  localparam logic [7:0] BSC_OFS_MODE   = 8'h04;
  localparam logic [7:0] BSC_OFS_MNAME  = 8'h08;
  localparam logic [7:0] BSC_OFS_NOM    = 8'h0c;
  localparam logic [7:0] BSC_OFS_STAGE  = 8'h10;
  localparam logic [7:0] BSC_OFS_SEC_HI = 8'h14;
  localparam logic [7:0] BSC_OFS_SEC_LO = 8'h18;
  localparam logic [7:0] BSC_OFS_AUX    = 8'h1c;
  localparam logic [7:0] BSC_OFS_SWAP   = 8'h20;
  localparam logic [7:0] BSC_OFS_CNTEN  = 8'h24;
  localparam logic [7:0] BSC_OFS_SEQPTR = 8'h28;
  localparam logic [7:0] BSC_OFS_SEQ    = 8'h2c;
  localparam logic [7:0] BSC_OFS_BCLR   = 8'h30;
  localparam logic [7:0] BSC_OFS_CCLR   = 8'h34;
  localparam logic [7:0] BSC_OFS_STAT   = 8'h38;
  localparam logic [7:0] BSC_OFS_BIN    = 8'h40;
  localparam logic [7:0] BSC_OFS_CNT    = 8'h90;

  // Status fields
  localparam int BSC_STAT_ERR   = 0;
  localparam int BSC_STAT_CODE  = 4;

  // Result codes
  localparam logic [3:0] BSC_CODE_OUT = 4'ha;
  localparam logic [3:0] BSC_CODE_AUX = 4'hb;

  // Mode names as ASCII words
  localparam logic [31:0] BSC_NAME_ABS = 32'h41544f4c;
  localparam logic [31:0] BSC_NAME_PCT = 32'h50544f4c;
  localparam logic [31:0] BSC_NAME_SEQ = 32'h53455120;

  // On/off codes: digits and their character codes
  localparam logic [31:0] BSC_ON_NUM   = 32'h00000001;
  localparam logic [31:0] BSC_OFF_NUM  = 32'h00000000;
  localparam logic [31:0] BSC_ON_CHR   = 32'h00000031;
  localparam logic [31:0] BSC_OFF_CHR  = 32'h00000030;

  localparam bsc_val_t  BSC_VAL_RST    = 32'sh00000000;
  localparam bsc_val_t  BSC_PCT_SCALE  = 32'sh00000064;

  function automatic logic bsc_onoff_ok(input logic [31:0] v);
    return (v == BSC_ON_NUM) || (v == BSC_OFF_NUM) ||
           (v == BSC_ON_CHR) || (v == BSC_OFF_CHR);
  endfunction

  function automatic logic bsc_onoff_val(input logic [31:0] v);
    return (v == BSC_ON_NUM) || (v == BSC_ON_CHR);
  endfunction

  function automatic logic bsc_within(input logic signed [65:0] v,
                                      input logic signed [65:0] lo,
                                      input logic signed [65:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

endpackage

// File: rtl/bsc_classify.sv
/*
 * Classification stage: sorts one measurement into a bin, the auxiliary
 * bin or out-of-bin, one registered result per measurement.
 * Assumes limit tables stay stable while a measurement is presented.
 */
`timescale 1ns/1ps
`default_nettype none

module bsc_classify
  import bsc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire bsc_meas_t              meas,
  input  wire logic                   enable,
  input  wire logic                   aux_en,
  input  wire logic                   swap,
  input  wire bsc_mode_t              mode,
  input  wire bsc_val_t               nominal,
  input  wire bsc_val_t [BSC_NBINS-1:0] bin_lo,
  input  wire bsc_val_t [BSC_NBINS-1:0] bin_hi,
  input  wire logic [BSC_NBINS-1:0]   bin_valid,
  input  wire bsc_val_t               sec_lo,
  input  wire bsc_val_t               sec_hi,
  input  wire logic                   sec_valid,
  output bsc_result_t                 result
);

  bsc_val_t              main_v;
  bsc_val_t              side_v;
  logic signed [65:0]    dev;
  logic signed [65:0]    dev_s;
  logic [BSC_NBINS-1:0]  hit;
  logic                  side_ok;
  logic [3:0]            code_nxt;

  function automatic logic signed [65:0] ext(input bsc_val_t v);
    return 66'(v);
  endfunction

  always_comb begin
    main_v = swap ? meas.secondary : meas.primary;
    side_v = swap ? meas.primary : meas.secondary;
  end

  // Percent scaling avoids a divider: deviation*100 against limit*nominal.
  // Limitation: percent mode assumes a positive nominal.
  always_comb begin
    dev   = ext(main_v) - ext(nominal);
    dev_s = 66'(dev * ext(BSC_PCT_SCALE));
  end

  always_comb begin
    hit = '0;
    for (int k = 0; k < BSC_NBINS; k++) begin
      case (mode)
        BSC_MODE_ABS: hit[k] = bsc_within(dev, ext(bin_lo[k]),
                                          ext(bin_hi[k]));
        BSC_MODE_PCT: hit[k] = bsc_within(dev_s,
                          66'(ext(bin_lo[k]) * ext(nominal)),
                          66'(ext(bin_hi[k]) * ext(nominal)));
        BSC_MODE_SEQ: hit[k] = bsc_within(ext(main_v), ext(bin_lo[k]),
                                          ext(bin_hi[k]));
        default:      hit[k] = 1'b0;
      endcase
      hit[k] = hit[k] & bin_valid[k];
    end
    side_ok = !sec_valid || bsc_within(ext(side_v), ext(sec_lo),
                                       ext(sec_hi));
  end

  always_comb begin
    code_nxt = BSC_CODE_OUT;
    for (int k = BSC_NBINS - 1; k >= 0; k--) begin
      if (hit[k] && side_ok) begin
        code_nxt = 4'(k + 1);
      end
    end
    if (code_nxt == BSC_CODE_OUT && aux_en && (|hit)) begin
      code_nxt = BSC_CODE_AUX;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      result <= '0;
    end else begin
      result.valid <= meas.valid && enable;
      result.code  <= (meas.valid && enable) ? code_nxt : result.code;
    end
  end

endmodule // bsc_classify

`default_nettype wire

// File: dv/bsc_host.sv
/*
 * APB master model standing for the remote host controller.
 * Assumes bsc_top on the same clock; the bench calls its task.
 */
`timescale 1ns/1ps
`default_nettype none

module bsc_host
  import bsc_pkg::*;
(
  input  wire logic        clock,
  output bsc_apb_req_t     apb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial apb = '0;

  // Request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clock);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb.penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb <= '0;
  endtask
endmodule // bsc_host

`default_nettype wire

// File: dv/bsc_properties.sv
/*
 * Checker on the ports of bsc_top.
 * Assumes one clock and the synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module bsc_props
  import bsc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire bsc_apb_req_t apb,
  input  wire logic [31:0]  prdata,
  input  wire logic         pready,
  input  wire logic         pslverr,
  input  wire bsc_meas_t    meas,
  input  wire bsc_result_t  result
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_setup;
    apb.psel && !apb.penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  sequence s_done;
    apb.psel && apb.penable && pready;
  endsequence

  property p_wait; s_setup |=> s_answer; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_in_acc; pready |-> apb.psel && apb.penable; endproperty
  property p_err_rdy; pslverr |-> pready; endproperty
  property p_unmap; s_done and apb.paddr > 8'hb8 |-> pslverr;
  endproperty
  property p_map;
    s_done and (apb.paddr <= 8'h38) && (apb.paddr[1:0] == 2'b00)
    |-> !pslverr;
  endproperty
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  property p_res_cause; result.valid |-> $past(meas.valid);
  endproperty
  property p_res_code;
    result.valid |-> result.code inside {[4'h1:4'hb]};
  endproperty

  a_wait: assert property (p_wait) else $error("no single wait");
  a_pulse: assert property (p_pulse) else $error("pready long");
  a_in_acc: assert property (p_in_acc) else $error("stray pready");
  a_err_rdy: assert property (p_err_rdy) else $error("stray err");
  a_unmap: assert property (p_unmap) else $error("unmapped ok");
  a_map: assert property (p_map) else $error("mapped err");
  a_rd_idle: assert property (p_rd_idle) else $error("prdata idle");
  a_res_cause: assert property (p_res_cause) else $error("res");
  a_res_code: assert property (p_res_code) else $error("code");
endmodule // bsc_props

bind bsc_top bsc_props bsc_props_inst (.clock(clock), .rstn(rstn),
  .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas(meas), .result(result));

`default_nettype wire

// File: dv/test_bin_sorting_comparator.sv
/*
 * Self-checking bench of bsc_top with the host model.
 * Assumes the package offsets and a one-wait-state APB slave.
 */
`timescale 1ns/1ps
`default_nettype none

module test_bin_sorting_comparator
  import bsc_pkg::*;
;
  logic         clock;
  logic         rstn;
  bsc_apb_req_t apb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  bsc_meas_t    meas;
  bsc_result_t  result;
  int           fails;
  int           n_compared;
  int           cyc;
  logic [31:0]  q;
  logic         e;

  bsc_top bsc_top_inst (.clock(clock), .rstn(rstn), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .result(result));
  bsc_host bsc_host_inst (.clock(clock), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, far above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bsc_host_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string n);
    bsc_host_inst.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask
  task automatic err(input logic x);
    bsc_host_inst.xfer(1'b0, BSC_OFS_STAT, 32'h0, q, e);
    chk("stat_err", 32'(x), 32'(q[0]));
    wr(BSC_OFS_STAT, 32'h1);
  endtask
  task automatic pair(input logic [7:0] a, input int l, input int h);
    wr(BSC_OFS_STAGE, 32'(l));
    wr(a, 32'(h));
  endtask
  // x[4] set when a result is due, x[3:0] its code
  task automatic m1(input int p, input int s, input logic [4:0] x);
    @(posedge clock);
    meas <= '{1'b1, 32'(p), 32'(s)};
    @(posedge clock);
    meas.valid <= 1'b0;
    #1;
    chk("res_valid", 32'(x[4]), 32'(result.valid));
    if (x[4])
      chk("res_code", 32'(x[3:0]), 32'(result.code));
  endtask

  task automatic t_onoff();
    logic [7:0] r[4] = '{BSC_OFS_STATE, BSC_OFS_AUX, BSC_OFS_SWAP,
                         BSC_OFS_CNTEN};
    foreach (r[i]) begin
      rd(r[i], 32'h0, "onoff_rst");
      wr(r[i], BSC_ON_CHR);
      rd(r[i], 32'h1, "onoff_49");
      wr(r[i], 32'h2);
      err(1'b1);
      rd(r[i], 32'h1, "onoff_keep");
      wr(r[i], BSC_OFF_CHR);
      rd(r[i], 32'h0, "onoff_48");
      wr(r[i], BSC_ON_NUM);
      rd(r[i], 32'h1, "onoff_1");
      wr(r[i], BSC_OFF_NUM);
      rd(r[i], 32'h0, "onoff_0");
    end
    bsc_host_inst.xfer(1'b0, 8'hfc, 32'h0, q, e);
    chk("unmapped", 32'h1, 32'(e));
  endtask

  task automatic t_mode();
    logic [31:0] nm[3] = '{BSC_NAME_ABS, BSC_NAME_PCT, BSC_NAME_SEQ};
    for (int i = 2; i >= 0; i--) begin
      wr(BSC_OFS_MODE, 32'(i));
      rd(BSC_OFS_MODE, 32'(i), "mode");
      rd(BSC_OFS_MNAME, nm[i], "mode_name");
    end
    wr(BSC_OFS_MODE, 32'h3);
    err(1'b1);
    rd(BSC_OFS_MODE, 32'h0, "mode_keep");
  endtask

  task automatic t_limits();
    wr(BSC_OFS_NOM, 32'h7b);
    rd(BSC_OFS_NOM, 32'h7b, "nominal");
    wr(BSC_OFS_NOM, 32'h0);
    for (int n = 1; n <= 9; n++) begin
      pair(BSC_OFS_BIN + 8'(8 * n - 4), -10 * n, 10 * n);
      rd(BSC_OFS_BIN + 8'(8 * n - 8), 32'(-10 * n), "bin_lo");
      rd(BSC_OFS_BIN + 8'(8 * n - 4), 32'(10 * n), "bin_hi");
    end
    pair(BSC_OFS_BIN + 8'h4, 7, 7);
    err(1'b1);
    rd(BSC_OFS_BIN + 8'h4, 32'd10, "bin_keep");
    pair(BSC_OFS_SEC_HI, 1, 100);
    rd(BSC_OFS_SEC_LO, 32'd1, "sec_lo");
    rd(BSC_OFS_SEC_HI, 32'd100, "sec_hi");
    pair(BSC_OFS_SEC_HI, 100, 100);
    err(1'b1);
  endtask

  task automatic t_class();
    logic [31:0] c[11] = '{2, 1, 0, 0, 1, 0, 0, 0, 0, 2, 2};
    wr(BSC_OFS_STATE, 32'h1);
    wr(BSC_OFS_CNTEN, 32'h1);
    m1(5, 50, 5'h11);
    m1(15, 50, 5'h12);
    m1(1000, 50, 5'h1a);
    m1(5, 200, 5'h1a);
    wr(BSC_OFS_AUX, 32'h1);
    m1(5, 200, 5'h1b);
    wr(BSC_OFS_SWAP, 32'h1);
    m1(50, 5, 5'h11);
    m1(5, 50, 5'h15);
    // Primary now judged by the secondary limits
    m1(200, 5, 5'h1b);
    rd(BSC_OFS_STAT, 32'hb0, "last_code");
    wr(BSC_OFS_SWAP, 32'h0);
    foreach (c[i])
      rd(BSC_OFS_CNT + 8'(4 * i), c[i], "count");
    wr(BSC_OFS_CNTEN, 32'h0);
    m1(5, 50, 5'h11);
    rd(BSC_OFS_CNT, 32'd2, "count_held");
    wr(BSC_OFS_STATE, 32'h0);
    m1(5, 50, 5'h00);
    wr(BSC_OFS_CCLR, 32'h1);
    foreach (c[i])
      rd(BSC_OFS_CNT + 8'(4 * i), 32'h0, "count_clr");
    wr(BSC_OFS_MODE, 32'h1);
    wr(BSC_OFS_NOM, 32'd200);
    wr(BSC_OFS_STATE, 32'h1);
    m1(215, 50, 5'h11);
  endtask

  task automatic t_seq();
    wr(BSC_OFS_MODE, 32'h2);
    wr(BSC_OFS_SEQPTR, 32'h0);
    for (int i = 0; i < 10; i++)
      wr(BSC_OFS_SEQ, 32'(10 * i + 10));
    wr(BSC_OFS_SEQ, 32'd200);
    err(1'b1);
    rd(BSC_OFS_SEQPTR, 32'd10, "seq_len");
    rd(BSC_OFS_BIN + 8'h8, 32'd20, "seq_lo2");
    // Read pointer still at the start: a pointer write would drop the list
    for (int i = 0; i < 10; i++)
      rd(BSC_OFS_SEQ, 32'(10 * i + 10), "seq_entry");
    m1(25, 50, 5'h12);
    m1(20, 50, 5'h11);
    // Limit clear leaves every measurement outside the bins
    wr(BSC_OFS_BCLR, 32'h1);
    rd(BSC_OFS_BIN + 8'hc, 32'h0, "bin_clr");
    m1(25, 50, 5'h1a);
  endtask

  initial begin
    fails = 0;
    n_compared = 0;
    cyc = 0;
    rstn = 1'b0;
    meas = '0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_onoff();
    t_mode();
    t_limits();
    t_class();
    t_seq();
    results();
  end
endmodule // test_bin_sorting_comparator

`default_nettype wire
